//--- iccd_pkg.sv
// Shared constants and types for the init config, gamma table and DAC block
package iccd_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_MHZ       = 40;
  localparam int DAC_SETUP_NS  = 25;
  localparam int DAC_STROBE_NS = 100;
  localparam int DAC_HOLD_NS   = 25;

  // Least times round up to whole cycles, never below one
  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int DAC_SETUP_CYC  = ns_to_cycles(DAC_SETUP_NS);
  localparam int DAC_STROBE_CYC = ns_to_cycles(DAC_STROBE_NS);
  localparam int DAC_HOLD_CYC   = ns_to_cycles(DAC_HOLD_NS);

  // ==========================================================================
  // Register selection on the register port
  typedef enum logic [2:0] {
    SEL_CFG_B   = 3'h1,
    SEL_CFG_C   = 3'h2,
    SEL_CFG_D   = 3'h3,
    SEL_GAMMA   = 3'h4,
    SEL_DAC     = 3'h5,
    SEL_DELTA   = 3'h6
  } iccd_reg_sel_t;

  // ==========================================================================
  // Third init register layout
  localparam int C_TRI_ALIAS_BIT = 0;
  localparam int C_VFIFO_LSB     = 1;
  localparam int C_TEX_DIS_BIT   = 6;
  localparam int C_STRAP_LSB     = 8;
  localparam int C_TEX_DLY_LSB   = 13;
  localparam int C_TEX_FULL_LSB  = 17;
  localparam int C_YSUB_LSB      = 22;
  localparam logic [31:0] CFG_C_WR_MASK = 32'hFFFF_E07F;
  localparam logic [31:0] CFG_C_RESET   = 32'h001E_4000;
  localparam logic [31:0] FORCED_PCI_BASE = 32'h1F00_0000;

  // Fourth init register layout
  localparam int D_RD_WS_BIT     = 0;
  localparam int D_RD_AHEAD_BIT  = 1;
  localparam int D_LOW_WATER_LSB = 2;
  localparam int D_ROW_START_LSB = 8;
  localparam int D_ROW_WRAP_LSB  = 18;
  localparam logic [31:0] CFG_D_WR_MASK = 32'h0FFF_FFFF;
  localparam logic [31:0] CFG_D_RESET   = 32'h0000_0001;

  // Gamma load word and DAC access word
  localparam int GAMMA_IDX_LSB   = 24;
  localparam int GAMMA_ENTRIES   = 33;
  localparam int DAC_ADDR_LSB    = 8;
  localparam int DAC_READ_BIT    = 11;
  localparam logic [23:0] DELTA_RESET = 24'h00_0000;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } iccd_rgb_t;

  typedef struct packed {
    logic       read;
    logic [2:0] addr;
    logic [7:0] data;
  } iccd_dac_req_t;

endpackage

//--- iccd_gamma.sv
// Gamma lookup table with three-channel linear interpolation
`timescale 1ns/1ps
`default_nettype none
module iccd_gamma (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              wr_en,
  input  wire logic [5:0]        wr_idx,
  input  wire iccd_pkg::iccd_rgb_t wr_rgb,
  input  wire logic              pix_valid,
  input  wire iccd_pkg::iccd_rgb_t pix_in,
  output logic                   out_valid,
  output iccd_pkg::iccd_rgb_t    out_rgb
);
  import iccd_pkg::*;

  logic [23:0] table_reg [GAMMA_ENTRIES];
  iccd_rgb_t   out_rgb_next;

  // Blend two neighbours: e0 + (e1 - e0) * f / 8, done without signs
  function automatic logic [7:0] interp(input logic [7:0] e0,
                                        input logic [7:0] e1,
                                        input logic [2:0] f);
    logic [11:0] sum;
    sum = 12'(e0) * 12'(4'h8 - {1'b0, f}) + 12'(e1) * 12'(f);
    return sum[10:3];
  endfunction

  // Five upper bits pick the entry, three lower bits the blend
  function automatic logic [7:0] chan(input logic [7:0] c, input int sh);
    logic [23:0] a;
    logic [23:0] b;
    a = table_reg[c[7:3]];
    b = table_reg[6'(c[7:3]) + 6'h01];
    return interp(a[sh +: 8], b[sh +: 8], c[2:0]);
  endfunction

  // Lookup for all three channels
  always_comb begin
    out_rgb_next.red   = chan(pix_in.red, 16);
    out_rgb_next.green = chan(pix_in.green, 8);
    out_rgb_next.blue  = chan(pix_in.blue, 0);
  end

  // Table has no reset; only index 0..32 is stored
  always_ff @(posedge clk) begin
    if (wr_en && wr_idx < 6'(GAMMA_ENTRIES)) begin
      table_reg[wr_idx] <= wr_rgb;
    end
  end

  // One cycle of latency from pixel to corrected pixel
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_valid <= 1'b0;
      out_rgb   <= 24'h00_0000;
    end else begin
      out_valid <= pix_valid;
      out_rgb   <= out_rgb_next;
    end
  end
endmodule
`default_nettype wire

//--- iccd_dac.sv
// Sequencer for one external DAC register access over the shared data lines
`timescale 1ns/1ps
`default_nettype none
module iccd_dac (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  start,
  input  wire iccd_pkg::iccd_dac_req_t req,
  input  wire logic [7:0]            dac_din,
  output logic                       busy,
  output logic [2:0]                 dac_addr,
  output logic [7:0]                 dac_dout,
  output logic                       dac_oe,
  output logic                       dac_wr_n,
  output logic                       dac_rd_n,
  output logic [7:0]                 rd_byte
);
  import iccd_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETUP  = 2'b01,
    ST_STROBE = 2'b10,
    ST_HOLD   = 2'b11
  } iccd_dac_st_t;

  iccd_dac_st_t  st_reg, st_next;
  logic [3:0]    cnt_reg, cnt_next;
  iccd_dac_req_t req_reg, req_next;
  logic [7:0]    rd_reg, rd_next;
  logic [7:0]    din_meta_reg, din_sync_reg;

  // Sequence: setup, strobe, hold; a start while busy is dropped
  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg - 4'h1;
    req_next = req_reg;
    rd_next  = rd_reg;
    case (st_reg)
      ST_IDLE: begin
        cnt_next = 4'(DAC_SETUP_CYC - 1);
        if (start) begin
          req_next = req;
          st_next  = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (cnt_reg == 4'h0) begin
          st_next  = ST_STROBE;
          cnt_next = 4'(DAC_STROBE_CYC - 1);
        end
      end
      ST_STROBE: begin
        if (cnt_reg == 4'h0) begin
          // Sampled through the synchroniser, so data must be stable early
          if (req_reg.read) begin
            rd_next = din_sync_reg;
          end
          st_next  = ST_HOLD;
          cnt_next = 4'(DAC_HOLD_CYC - 1);
        end
      end
      ST_HOLD: begin
        if (cnt_reg == 4'h0) begin
          st_next = ST_IDLE;
        end
      end
      default: st_next = ST_IDLE;
    endcase
  end

  // State, pins and the read holding register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_reg       <= ST_IDLE;
      cnt_reg      <= 4'h0;
      req_reg      <= 12'h000;
      rd_reg       <= 8'h00;
      din_meta_reg <= 8'h00;
      din_sync_reg <= 8'h00;
      busy         <= 1'b0;
      dac_addr     <= 3'h0;
      dac_dout     <= 8'h00;
      dac_oe       <= 1'b0;
      dac_wr_n     <= 1'b1;
      dac_rd_n     <= 1'b1;
    end else begin
      st_reg       <= st_next;
      cnt_reg      <= cnt_next;
      req_reg      <= req_next;
      rd_reg       <= rd_next;
      din_meta_reg <= dac_din;
      din_sync_reg <= din_meta_reg;
      busy         <= (st_next != ST_IDLE);
      dac_addr     <= req_next.addr;
      dac_dout     <= req_next.data;
      dac_oe       <= (st_next != ST_IDLE) && !req_next.read;
      dac_wr_n     <= !((st_next == ST_STROBE) && !req_next.read);
      dac_rd_n     <= !((st_next == ST_STROBE) && req_next.read);
    end
  end

  assign rd_byte = rd_reg;
endmodule
`default_nettype wire

//--- iccd_regs.sv
// Late init registers, gamma table loader, DAC port and filter deltas
`timescale 1ns/1ps
`default_nettype none
module iccd_regs (
  input  wire logic                    CLK,
  input  wire logic                    RESET,
  // Register port
  input  wire logic                    REG_WR,
  input  wire logic                    REG_RD,
  input  wire iccd_pkg::iccd_reg_sel_t REG_SEL,
  input  wire logic [31:0]             REG_WDATA,
  output logic [31:0]                  REG_RDATA,
  // Configuration-space and first-register bits
  input  wire logic                    PCI_INIT_WRITE_PERMIT,
  input  wire logic                    PCI_INIT_REMAP,
  input  wire logic                    INIT_A_EDGE_FILTER,
  // Power-on straps
  input  wire logic [4:0]              STRAP_PINS,
  // PCI FIFO watermark
  input  wire logic [5:0]              PCI_FIFO_FREE,
  output logic                         MEM_FIFO_SPILL,
  // Configuration outputs
  output logic                         TRI_ALIAS_MAP,
  output logic [4:0]                   VIDEO_FIFO_THRESH,
  output logic                         TEX_IF_DISABLE,
  output logic [3:0]                   TEX_CLK_DELAY,
  output logic [4:0]                   TEX_FIFO_FULL_THRESH,
  output logic [9:0]                   Y_ORIGIN_SUB,
  output logic                         PCI_READ_WS2,
  output logic                         LFB_READ_AHEAD,
  output logic [9:0]                   MEM_FIFO_ROW_START,
  output logic [9:0]                   MEM_FIFO_ROW_WRAP,
  output logic [2:0]                   MEM_TYPE,
  output logic                         PASSTHRU_RESET_VAL,
  output logic                         FORCE_PCI_BASE,
  output logic                         FILTER_ENABLE,
  output iccd_pkg::iccd_rgb_t          FILTER_MAX_DELTA,
  // Video refresh path
  input  wire logic                    PIX_VALID,
  input  wire iccd_pkg::iccd_rgb_t     PIX_IN,
  output logic                         GAMMA_VALID,
  output iccd_pkg::iccd_rgb_t          GAMMA_OUT,
  // External DAC on the shared data lines
  output logic [2:0]                   DAC_ADDR,
  output logic [7:0]                   DAC_DATA_OUT,
  output logic                         DAC_DATA_OE,
  input  wire logic [7:0]              DAC_DATA_IN,
  output logic                         DAC_WR_N,
  output logic                         DAC_RD_N,
  output logic                         DAC_BUSY
);
  import iccd_pkg::*;

  // ==========================================================================
  // Declarations
  logic [31:0]   cfg_c_reg, cfg_c_next;
  logic [31:0]   cfg_d_reg, cfg_d_next;
  iccd_rgb_t     delta_reg, delta_next;
  logic [4:0]    strap_meta_reg, strap_sync_reg;
  logic [4:0]    strap_reg, strap_next;
  logic [1:0]    strap_age_reg, strap_age_next;
  logic          spill_reg, spill_next;
  logic          filter_reg, filter_next;
  logic [31:0]   rdata_reg, rdata_next;
  logic          gamma_wr;
  logic          dac_start;
  iccd_dac_req_t dac_req;
  logic [7:0]    dac_byte;

  // Merge a write under a mask so fixed bits keep their stored value
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] mask);
    return (new_v & mask) | (old_v & ~mask);
  endfunction

  // ==========================================================================
  // Init registers: written directly, never queued behind the PCI FIFO
  always_comb begin
    cfg_c_next = cfg_c_reg;
    cfg_d_next = cfg_d_reg;
    delta_next = delta_reg;
    // Permit check guards against stray writes during bring-up
    if (REG_WR && PCI_INIT_WRITE_PERMIT) begin
      if (REG_SEL == SEL_CFG_C) begin
        cfg_c_next = merge(cfg_c_reg, REG_WDATA, CFG_C_WR_MASK);
      end
      if (REG_SEL == SEL_CFG_D) begin
        cfg_d_next = merge(cfg_d_reg, REG_WDATA, CFG_D_WR_MASK);
      end
    end
    // Filter deltas are not behind the permit
    if (REG_WR && REG_SEL == SEL_DELTA) begin
      delta_next = REG_WDATA[23:0];
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cfg_c_reg <= CFG_C_RESET;
      cfg_d_reg <= CFG_D_RESET;
      delta_reg <= DELTA_RESET;
    end else begin
      cfg_c_reg <= cfg_c_next;
      cfg_d_reg <= cfg_d_next;
      delta_reg <= delta_next;
    end
  end

  // ==========================================================================
  // Straps: synchronised, then frozen on the third edge after release.
  // Later pin wiggles are ignored so the read value stays stable.
  always_comb begin
    strap_next     = strap_reg;
    strap_age_next = strap_age_reg;
    // The sync stage only shows the pins two edges after release
    if (strap_age_reg != 2'h3) begin
      strap_age_next = strap_age_reg + 2'h1;
      strap_next     = strap_sync_reg;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      strap_meta_reg  <= 5'h00;
      strap_sync_reg  <= 5'h00;
      strap_reg       <= 5'h00;
      strap_age_reg   <= 2'h0;
    end else begin
      strap_meta_reg  <= STRAP_PINS;
      strap_sync_reg  <= strap_meta_reg;
      strap_reg       <= strap_next;
      strap_age_reg   <= strap_age_next;
    end
  end

  // ==========================================================================
  // Spill request and filter enable, one register stage each
  always_comb begin
    spill_next  = PCI_FIFO_FREE <
                  cfg_d_reg[D_LOW_WATER_LSB +: 6];
    filter_next = INIT_A_EDGE_FILTER;
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      spill_reg  <= 1'b0;
      filter_reg <= 1'b0;
    end else begin
      spill_reg  <= spill_next;
      filter_reg <= filter_next;
    end
  end

  // ==========================================================================
  // Read-back, one cycle after the read strobe
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (REG_RD) begin
      case (REG_SEL)
        SEL_CFG_B: begin
          // Only the remapped view belongs here; the rest reads zero
          if (PCI_INIT_REMAP) begin
            rdata_next = {24'h00_0000, dac_byte};
          end
        end
        SEL_CFG_C: begin
          rdata_next = cfg_c_reg;
          rdata_next[C_STRAP_LSB +: 5] = strap_reg;
        end
        SEL_CFG_D: rdata_next = cfg_d_reg;
        SEL_DELTA: rdata_next = {8'h00, delta_reg};
        default:   rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================================
  // Outputs, each a field of a register
  always_comb begin
    REG_RDATA            = rdata_reg;
    MEM_FIFO_SPILL       = spill_reg;
    TRI_ALIAS_MAP        = cfg_c_reg[C_TRI_ALIAS_BIT];
    VIDEO_FIFO_THRESH    = cfg_c_reg[C_VFIFO_LSB +: 5];
    TEX_IF_DISABLE       = cfg_c_reg[C_TEX_DIS_BIT];
    TEX_CLK_DELAY        = cfg_c_reg[C_TEX_DLY_LSB +: 4];
    TEX_FIFO_FULL_THRESH = cfg_c_reg[C_TEX_FULL_LSB +: 5];
    Y_ORIGIN_SUB         = cfg_c_reg[C_YSUB_LSB +: 10];
    PCI_READ_WS2         = cfg_d_reg[D_RD_WS_BIT];
    LFB_READ_AHEAD       = cfg_d_reg[D_RD_AHEAD_BIT];
    MEM_FIFO_ROW_START   = cfg_d_reg[D_ROW_START_LSB +: 10];
    MEM_FIFO_ROW_WRAP    = cfg_d_reg[D_ROW_WRAP_LSB +: 10];
    MEM_TYPE             = strap_reg[2:0];
    PASSTHRU_RESET_VAL   = strap_reg[3];
    FORCE_PCI_BASE       = strap_reg[4];
    FILTER_ENABLE        = filter_reg;
    FILTER_MAX_DELTA     = delta_reg;
  end

  // ==========================================================================
  // Gamma table load and refresh lookup
  assign gamma_wr = REG_WR && (REG_SEL == SEL_GAMMA);

  iccd_gamma u_gamma (
    .clk       (CLK),
    .reset     (RESET),
    .wr_en     (gamma_wr),
    .wr_idx    (REG_WDATA[GAMMA_IDX_LSB +: 6]),
    .wr_rgb    (REG_WDATA[23:0]),
    .pix_valid (PIX_VALID),
    .pix_in    (PIX_IN),
    .out_valid (GAMMA_VALID),
    .out_rgb   (GAMMA_OUT)
  );

  // ==========================================================================
  // DAC access: no arbitration with the memory controller here, the host
  // must idle the memory bus first, so the data lines are driven blindly
  assign dac_start    = REG_WR && (REG_SEL == SEL_DAC);
  assign dac_req.read = REG_WDATA[DAC_READ_BIT];
  assign dac_req.addr = REG_WDATA[DAC_ADDR_LSB +: 3];
  assign dac_req.data = REG_WDATA[7:0];

  iccd_dac u_dac (
    .clk      (CLK),
    .reset    (RESET),
    .start    (dac_start),
    .req      (dac_req),
    .dac_din  (DAC_DATA_IN),
    .busy     (DAC_BUSY),
    .dac_addr (DAC_ADDR),
    .dac_dout (DAC_DATA_OUT),
    .dac_oe   (DAC_DATA_OE),
    .dac_wr_n (DAC_WR_N),
    .dac_rd_n (DAC_RD_N),
    .rd_byte  (dac_byte)
  );
endmodule
`default_nettype wire

//--- iccd_regs_properties.sv
// Port-level checks for the init config, gamma and DAC block
`timescale 1ns/1ps
`default_nettype none
module iccd_regs_chk
  import iccd_pkg::*;
(
  input wire logic                    CLK,
  input wire logic                    RESET,
  input wire logic                    REG_WR,
  input wire iccd_pkg::iccd_reg_sel_t REG_SEL,
  input wire logic [31:0]             REG_WDATA,
  input wire logic                    PCI_INIT_WRITE_PERMIT,
  input wire logic                    INIT_A_EDGE_FILTER,
  input wire logic [5:0]              PCI_FIFO_FREE,
  input wire logic                    MEM_FIFO_SPILL,
  input wire logic                    TRI_ALIAS_MAP,
  input wire logic [4:0]              VIDEO_FIFO_THRESH,
  input wire logic                    TEX_IF_DISABLE,
  input wire logic [3:0]              TEX_CLK_DELAY,
  input wire logic [4:0]              TEX_FIFO_FULL_THRESH,
  input wire logic [9:0]              Y_ORIGIN_SUB,
  input wire logic                    PCI_READ_WS2,
  input wire logic                    LFB_READ_AHEAD,
  input wire logic [9:0]              MEM_FIFO_ROW_START,
  input wire logic [9:0]              MEM_FIFO_ROW_WRAP,
  input wire logic                    FILTER_ENABLE,
  input wire logic                    PIX_VALID,
  input wire logic                    GAMMA_VALID,
  input wire logic [2:0]              DAC_ADDR,
  input wire logic [7:0]              DAC_DATA_OUT,
  input wire logic                    DAC_DATA_OE,
  input wire logic                    DAC_WR_N,
  input wire logic                    DAC_RD_N,
  input wire logic                    DAC_BUSY
);
  logic [31:0] wd_reg, wd_next;
  logic [5:0]  lwm_reg, lwm_next;
  logic        wr_c, wr_d, dac_go;

  // ======================================================
  // Helper decode and shadow state
  assign wr_c = REG_WR && REG_SEL == SEL_CFG_C && PCI_INIT_WRITE_PERMIT;
  assign wr_d = REG_WR && REG_SEL == SEL_CFG_D && PCI_INIT_WRITE_PERMIT;
  assign dac_go = REG_WR && REG_SEL == SEL_DAC && !DAC_BUSY;

  // Shadow of the low water mark, since it is not visible at a port
  always_comb begin
    wd_next  = REG_WDATA;
    lwm_next = wr_d ? REG_WDATA[7:2] : lwm_reg;
  end
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      wd_reg  <= 32'h0000_0000;
      lwm_reg <= 6'h00;
    end else begin
      wd_reg  <= wd_next;
      lwm_reg <= lwm_next;
    end
  end

  // ======================================================
  // Assertions
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);

  chk_permit_gate: assert property (
    REG_WR && !PCI_INIT_WRITE_PERMIT |=> $stable(TRI_ALIAS_MAP)
      && $stable(Y_ORIGIN_SUB) && $stable(MEM_FIFO_ROW_WRAP))
    else $error("init field moved without write permit");
  chk_cfg_c_low: assert property (
    wr_c |=> TRI_ALIAS_MAP == wd_reg[0] && TEX_IF_DISABLE == wd_reg[6]
      && VIDEO_FIFO_THRESH == wd_reg[5:1])
    else $error("low fields of third register wrong");
  chk_cfg_c_high: assert property (
    wr_c |=> {Y_ORIGIN_SUB, TEX_FIFO_FULL_THRESH, TEX_CLK_DELAY}
      == wd_reg[31:13])
    else $error("high fields of third register wrong");
  chk_cfg_d_fields: assert property (
    wr_d |=> {MEM_FIFO_ROW_WRAP, MEM_FIFO_ROW_START} == wd_reg[27:8]
      && {LFB_READ_AHEAD, PCI_READ_WS2} == wd_reg[1:0])
    else $error("fourth register fields wrong");
  chk_spill_level: assert property (
    MEM_FIFO_SPILL == ($past(PCI_FIFO_FREE) < $past(lwm_reg)))
    else $error("spill level does not follow free space");
  chk_dac_write: assert property (
    dac_go && !REG_WDATA[11] |=> DAC_BUSY && DAC_DATA_OE
      && {DAC_ADDR, DAC_DATA_OUT} == wd_reg[10:0] ##1 !DAC_WR_N [*4]
      ##1 DAC_WR_N ##1 !DAC_BUSY)
    else $error("external write cycle malformed");
  chk_dac_read: assert property (
    dac_go && REG_WDATA[11] |=> DAC_BUSY && !DAC_DATA_OE
      && DAC_ADDR == wd_reg[10:8] ##1 (!DAC_RD_N && DAC_WR_N) [*4]
      ##1 DAC_RD_N ##1 !DAC_BUSY)
    else $error("external read cycle malformed");
  chk_gamma_valid: assert property (
    !$past(RESET) |-> GAMMA_VALID == $past(PIX_VALID))
    else $error("gamma valid not one cycle after pixel");
  chk_filter_gate: assert property (
    !$past(RESET) |-> FILTER_ENABLE == $past(INIT_A_EDGE_FILTER))
    else $error("filter enable does not follow its bit");

  cov_refused: cover property (REG_WR && !PCI_INIT_WRITE_PERMIT);
  cov_dac_wr: cover property (dac_go && !REG_WDATA[11]);
  cov_dac_rd: cover property (dac_go && REG_WDATA[11]);
  cov_spill: cover property ($rose(MEM_FIFO_SPILL));
endmodule

bind iccd_regs iccd_regs_chk iccd_regs_chk_inst (.*);
`default_nettype wire

//--- iccd_dac_model.sv
// Behavioural model of the external DAC on the shared data lines
`timescale 1ns/1ps
`default_nettype none
module iccd_dac_model (
  input  wire logic       clk,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] bus_in,
  input  wire logic       wr_n,
  input  wire logic       rd_n,
  output logic      [7:0] bus_out
);
  logic [7:0] regs [0:7];
  logic [7:0] last = 8'h5A;

  // ======================================================
  // Write lands as the strobe rises, while data is still driven
  always @(posedge wr_n) begin
    regs[addr] <= bus_in;
  end

  // Released lines show the inverse of the last byte, never a stale copy
  always_comb begin
    bus_out = rd_n ? ~last : regs[addr];
  end
  always @(posedge clk) begin
    if (!rd_n) last <= regs[addr];
  end
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking testbench for the init config, gamma and DAC block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import iccd_pkg::*;
  logic          CLK, RESET, REG_WR, REG_RD, PIX_VALID, p;
  logic          PCI_INIT_WRITE_PERMIT, PCI_INIT_REMAP, INIT_A_EDGE_FILTER;
  logic          MEM_FIFO_SPILL, TRI_ALIAS_MAP, TEX_IF_DISABLE, PCI_READ_WS2;
  logic          LFB_READ_AHEAD, PASSTHRU_RESET_VAL, FORCE_PCI_BASE;
  logic          FILTER_ENABLE, GAMMA_VALID, DAC_DATA_OE, DAC_WR_N;
  logic          DAC_RD_N, DAC_BUSY;
  logic [2:0]    MEM_TYPE, DAC_ADDR, a;
  logic [3:0]    TEX_CLK_DELAY;
  logic [4:0]    STRAP_PINS, VIDEO_FIFO_THRESH, TEX_FIFO_FULL_THRESH;
  logic [5:0]    PCI_FIFO_FREE;
  logic [7:0]    DAC_DATA_OUT, DAC_DATA_IN, mdl_out, d;
  logic [9:0]    Y_ORIGIN_SUB, MEM_FIFO_ROW_START, MEM_FIFO_ROW_WRAP;
  logic [31:0]   REG_WDATA, REG_RDATA, w, r, cc, cd;
  iccd_reg_sel_t REG_SEL;
  iccd_rgb_t     PIX_IN, GAMMA_OUT, FILTER_MAX_DELTA, px, prev;
  iccd_rgb_t     gt [0:32];
  int            n_mismatch, n_checks;

  // ======================================================
  // Design, external DAC and the shared data lines between them
  iccd_regs iccd_regs_inst (.*);
  iccd_dac_model iccd_dac_model_inst (.clk(CLK), .addr(DAC_ADDR),
    .bus_in(DAC_DATA_IN), .wr_n(DAC_WR_N), .rd_n(DAC_RD_N),
    .bus_out(mdl_out));
  assign DAC_DATA_IN = DAC_DATA_OE ? DAC_DATA_OUT : mdl_out;

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  // Free space and the edge filter bit wander every cycle
  always @(posedge CLK) begin
    PCI_FIFO_FREE <= 6'($urandom);
    INIT_A_EDGE_FILTER <= 1'($urandom);
  end

  // ======================================================
  // Tasks and expectation functions
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input iccd_reg_sel_t s, input logic [31:0] v);
    @(posedge CLK);
    REG_WR <= 1'b1;
    REG_SEL <= s;
    REG_WDATA <= v;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask
  // Read data stands one cycle only, so it is taken just after the edge
  task automatic rd(input iccd_reg_sel_t s, output logic [31:0] v);
    @(posedge CLK);
    REG_RD <= 1'b1;
    REG_SEL <= s;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1 v = REG_RDATA;
  endtask
  task automatic dac_idle();
    @(negedge CLK);
    for (int k = 0; k < 20 && DAC_BUSY !== 1'b0; k++) @(negedge CLK);
    chk("dac_busy", 32'h0, {31'h0, DAC_BUSY});
  endtask
  function automatic logic [7:0] lerp(input logic [7:0] e0, e1,
                                      input logic [2:0] f);
    logic [11:0] s;
    s = e0 * (12'd8 - f) + e1 * f;
    return s[10:3];
  endfunction
  function automatic iccd_rgb_t gam(input iccd_rgb_t x);
    iccd_rgb_t  o;
    logic [5:0] i;
    i = {1'b0, x.red[7:3]};
    o.red = lerp(gt[i].red, gt[i + 6'd1].red, x.red[2:0]);
    i = {1'b0, x.green[7:3]};
    o.green = lerp(gt[i].green, gt[i + 6'd1].green, x.green[2:0]);
    i = {1'b0, x.blue[7:3]};
    o.blue = lerp(gt[i].blue, gt[i + 6'd1].blue, x.blue[2:0]);
    return o;
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // The whole run needs well under a thousand cycles
  initial begin
    #125000;
    n_mismatch++;
    stop_test();
  end

  // ======================================================
  // Main sequence
  initial begin
    void'($urandom(49516));
    RESET = 1'b1;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_SEL = SEL_CFG_B;
    REG_WDATA = 32'h0;
    PCI_INIT_WRITE_PERMIT = 1'b0;
    PCI_INIT_REMAP = 1'b0;
    STRAP_PINS = 5'($urandom);
    PIX_VALID = 1'b0;
    PIX_IN = 24'h0;
    repeat (8) @(posedge CLK);
    RESET <= 1'b0;
    // Straps are frozen on the third edge after release
    repeat (2) @(posedge CLK);
    cc = CFG_C_RESET | {19'h0, STRAP_PINS, 8'h0};
    rd(SEL_CFG_C, r);
    chk("cfg_c", cc, r);
    chk("straps", {27'h0, STRAP_PINS},
        {27'h0, FORCE_PCI_BASE, PASSTHRU_RESET_VAL, MEM_TYPE});
    rd(SEL_CFG_D, r);
    chk("cfg_d", CFG_D_RESET, r);
    chk("rst_out", {22'h0, 4'h2, 5'hF, 1'b1},
        {22'h0, TEX_CLK_DELAY, TEX_FIFO_FULL_THRESH, PCI_READ_WS2});
    cd = CFG_D_RESET;
    // Corner words first, four writes (both of rounds 1 and 5) refused for lack of permit
    for (int i = 0; i < 8; i++) begin
      w = (i < 2) ? {32{~i[0]}} : $urandom;
      p = (i != 1) && (i != 5);
      PCI_INIT_WRITE_PERMIT <= p;
      wr(SEL_CFG_C, w);
      if (p) cc = (w & CFG_C_WR_MASK) | (cc & ~CFG_C_WR_MASK);
      wr(SEL_CFG_D, ~w);
      if (p) cd = ~w & CFG_D_WR_MASK;
      rd(SEL_CFG_C, r);
      chk("cfg_c", cc, r);
      rd(SEL_CFG_D, r);
      chk("cfg_d", cd, r);
    end
    w = $urandom;
    wr(SEL_DELTA, w);
    rd(SEL_DELTA, r);
    chk("delta", {8'h0, w[23:0]}, r);
    chk("delta_out", {8'h0, w[23:0]}, {8'h0, FILTER_MAX_DELTA});
    // Index 33 is out of range and must leave the table alone
    for (int i = 0; i < 34; i++) begin
      w = {2'b00, 6'(i), 24'($urandom)};
      if (i < 33) gt[i] = w[23:0];
      wr(SEL_GAMMA, w);
    end
    for (int j = 0; j < 25; j++) begin
      px = (j == 0) ? 24'hFFFFFF : (j == 1) ? 24'h0 : 24'($urandom);
      @(posedge CLK);
      PIX_VALID <= (j < 24);
      PIX_IN <= px;
      #1;
      if (j > 0) chk("gam", {8'h0, gam(prev)}, {8'h0, GAMMA_OUT});
      prev = px;
    end
    // Memory bus is idle here, nothing else uses the lines
    for (int i = 0; i < 4; i++) begin
      a = 3'($urandom);
      d = 8'($urandom);
      wr(SEL_DAC, {20'h0, 1'b0, a, d});
      wr(SEL_DAC, {20'h0, 1'b0, a, ~d});
      dac_idle();
      chk("dac_reg", {24'h0, d}, {24'h0, iccd_dac_model_inst.regs[a]});
      wr(SEL_DAC, {20'h0, 1'b1, a, 8'h00});
      dac_idle();
      PCI_INIT_REMAP <= i[0];
      rd(SEL_CFG_B, r);
      chk("dac_byte", i[0] ? {24'h0, d} : 32'h0,
          i[0] ? {24'h0, r[7:0]} : r);
    end
    stop_test();
  end
endmodule
`default_nettype wire
